/* File: icr_pkg.sv */
// Constants, codes and the state record of the two-wire controller registers.
// Assumes a 40 MHz system clock and AXI4-Lite byte addressing.
package icr_pkg;

  // ----------------------------------------------------------------
  // Register map and control bit positions
  // ----------------------------------------------------------------
  localparam logic [31:0] A_SET = 32'he001c000;
  localparam logic [31:0] A_STAT = 32'he001c004;
  localparam logic [31:0] A_DAT = 32'he001c008;
  localparam logic [31:0] A_ADR = 32'he001c00c;
  localparam logic [31:0] A_CLR = 32'he001c018;
  localparam int B_GC = 0;
  localparam int B_AA = 2;
  localparam int B_SI = 3;
  localparam int B_STO = 4;
  localparam int B_STA = 5;
  localparam int B_EN = 6;
  localparam logic [7:0] SET_MASK = 8'h7c;
  localparam logic [7:0] CLR_MASK = 8'h6c;
  localparam logic [4:0] STAT_RST = 5'h1f;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Status codes, full byte; the upper five bits are stored
  // ----------------------------------------------------------------
  localparam logic [7:0] C_START = 8'h08;
  localparam logic [7:0] C_RSTART = 8'h10;
  localparam logic [7:0] C_AW_ACK = 8'h18;
  localparam logic [7:0] C_AW_NAK = 8'h20;
  localparam logic [7:0] C_TX_ACK = 8'h28;
  localparam logic [7:0] C_TX_NAK = 8'h30;
  localparam logic [7:0] C_AR_ACK = 8'h40;
  localparam logic [7:0] C_AR_NAK = 8'h48;
  localparam logic [7:0] C_RX_ACK = 8'h50;
  localparam logic [7:0] C_RX_NAK = 8'h58;
  localparam logic [7:0] C_SW_OWN = 8'h60;
  localparam logic [7:0] C_SW_GC = 8'h70;
  localparam logic [7:0] C_SRX_ACK = 8'h80;
  localparam logic [7:0] C_SRX_NAK = 8'h88;
  localparam logic [7:0] C_GRX_ACK = 8'h90;
  localparam logic [7:0] C_GRX_NAK = 8'h98;
  localparam logic [7:0] C_SSTOP = 8'ha0;
  localparam logic [7:0] C_SR_OWN = 8'ha8;
  localparam logic [7:0] C_STX_ACK = 8'hb8;
  localparam logic [7:0] C_STX_NAK = 8'hc0;

  // ----------------------------------------------------------------
  // Timing: half of an SCL period, rounded up to whole clocks
  // ----------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int SCL_HALF_NS = 5000;
  localparam logic [7:0] HALF_CYC = 8'((SCL_HALF_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [3:0] {
    P_IDLE, P_START, P_LOW, P_HIGH, P_HOLD, P_SHOLD, P_STOP1, P_STOP2, P_RS1, P_RS2
  } icr_phase_t;

  typedef struct packed {
    logic awrdy, wrdy, arrdy, bvalid, rvalid, aw_got, w_got, wstb;
    logic [31:0] awaddr;
    logic [7:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic en, begin_condition_request, halt_condition_request, si, aa;
    logic [4:0] stat;
    logic [7:0] dat, adr;
    logic [2:0] scl_q, sda_q;
    icr_phase_t phase;
    logic [7:0] cnt;
    logic [3:0] bitcnt;
    logic mst, tx, first, addressed, slv_act, gc, busy, rs, ackb;
    logic scl_oe, sda_oe;
  } icr_st_t;

endpackage : icr_pkg

/* File: icr_ctrl.sv */
// Two-wire bus controller: control, status, data and own-address registers
// behind an AXI4-Lite slave, with a byte engine for master and slave modes.
// Assumes open-drain SCL/SDA resolved outside; pins are asynchronous.
// Function
// R1: Controller works only while enable bit 6 is one.
// R2: Disabled: pins ignored, not-addressed slave, stop request forced zero.
// R3: Control bits: ack 2, irq 3, stop 4, start 5; 3-5 reset zero.
// R4: Clear port ones clear ack, irq, start, enable bits.
// R5: Start from idle when bus free, else after Stop plus half period.
// R6: Start while master gives repeated Start; no Start without request.
// R7: Start and stop as master: Stop then Start; slave: internal Stop.
// R8: Master stop request sends Stop, cleared when Stop seen on bus.
// R9: Slave stop request: silent recovery to not-addressed, request cleared.
// R10: Interrupt flag set on each bus state change except idle.
// R11: Flag set stretches SCL low and suspends the transfer.
// R12: Only software clears the interrupt flag.
// R13: Ack set: drive ACK for own/general address and received data.
// R14: Ack clear: NACK on received data bytes.
// R15: Status register: code in bits 7:3, low bits zero, resets 0xF8.
// R16: Idle code F8 leaves flag clear; other codes set it.
// R17: Data byte stable while flag set; software accesses only then.
// R18: Shift left, bit 7 first out and first in.
// R19: Own address used only in slave mode; bit 0 enables general call.
// R20: Software must not use enable to release the bus.
// R21: Set port ones set control bits; read returns control register.
// R22: Status latched with flag set, stable until flag cleared.
// R23: Upper seven own-address bits compared with received address.
// R24: Reserved control bits ignore writes and read zero.
`timescale 1ns/100ps
module icr_ctrl (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  import icr_pkg::*;

  icr_st_t s, n;
  logic scl, sda, scl_r, scl_f, st_det, sp_det, wr, hit, hw_si;
  logic [7:0] set_w, clr_w, code;

  // Own-address match; general call only when enabled
  function automatic logic adr_hit(input icr_st_t x);
    adr_hit = (x.dat[7:1] == x.adr[7:1]) || (x.adr[B_GC] && x.dat[7:1] == 7'h00);
  endfunction : adr_hit

  // Level to present on SDA for the current bit (1 = released)
  function automatic logic ob(input icr_st_t x);
    logic ok;
    ok = x.first ? (!x.mst && x.aa && adr_hit(x)) : (x.aa && (x.mst || x.addressed));
    if (x.bitcnt < 4'd8) begin
      ob = x.tx ? x.dat[7] : 1'b1;
    end else begin
      ob = !(!x.tx && ok);
    end
  endfunction : ob

  // ----------------------------------------------------------------
  // Pin events and write decode
  // ----------------------------------------------------------------
  // Events use second sync stage and its delayed copy only; disabled = blind
  assign scl = s.scl_q[1];
  assign sda = s.sda_q[1];
  assign scl_r = s.en && scl && !s.scl_q[2];
  assign scl_f = s.en && !scl && s.scl_q[2];
  assign st_det = s.en && scl && s.scl_q[2] && !sda && s.sda_q[2];
  assign sp_det = s.en && scl && s.scl_q[2] && sda && !s.sda_q[2];
  assign wr = s.aw_got && s.w_got && !s.bvalid;
  assign hit = s.awaddr inside {A_SET, A_STAT, A_DAT, A_ADR, A_CLR};
  // R24 reserved bits masked
  assign set_w = (wr && s.wstb && s.awaddr == A_SET) ? (s.wdata & SET_MASK) : 8'h00;
  assign clr_w = (wr && s.wstb && s.awaddr == A_CLR) ? (s.wdata & CLR_MASK) : 8'h00;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    hw_si = 1'b0;
    code = 8'h00;
    n.scl_q = {s.scl_q[1:0], scl_i};
    n.sda_q = {s.sda_q[1:0], sda_i};
    // AXI write channels, taken in either order
    if (s_axi_awvalid_i && s.awrdy) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s.wrdy) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata_i[7:0];
      n.wstb = s_axi_wstrb_i[0];
    end
    if (s.bvalid && s_axi_bready_i) n.bvalid = 1'b0;
    if (wr) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = hit ? RESP_OK : RESP_SLVERR;
      // R17 software loads the byte; the write is taken whether or not the flag stands
      if (s.wstb && s.awaddr == A_DAT) n.dat = s.wdata;
      if (s.wstb && s.awaddr == A_ADR) n.adr = s.wdata;
    end
    // R21 R4 set and clear ports; R12 flag clear only from software
    n.en = (s.en | set_w[B_EN]) & ~clr_w[B_EN];
    n.begin_condition_request = (s.begin_condition_request | set_w[B_STA]) & ~clr_w[B_STA];
    n.si = (s.si | set_w[B_SI]) & ~clr_w[B_SI];
    n.aa = (s.aa | set_w[B_AA]) & ~clr_w[B_AA];
    n.halt_condition_request = s.halt_condition_request | set_w[B_STO];
    // AXI read, answered one cycle after the address is taken
    if (s.rvalid && s_axi_rready_i) n.rvalid = 1'b0;
    if (s_axi_arvalid_i && s.arrdy) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OK;
      case (s_axi_araddr_i)
        A_SET: n.rdata = {1'b0, s.en, s.begin_condition_request, s.halt_condition_request, s.si, s.aa, 2'b00};
        // R15 low bits zero
        A_STAT: n.rdata = {s.stat, 3'b000};
        A_DAT: n.rdata = s.dat;
        A_ADR: n.rdata = s.adr;
        A_CLR: n.rdata = 8'h00;
        default: begin
          n.rdata = 8'h00;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (!s.en || !n.en) begin
      // R1 R2 disabled or being disabled: not addressed, lines released, stop dropped
      n.phase = P_IDLE;
      n.mst = 1'b0;
      n.addressed = 1'b0;
      n.slv_act = 1'b0;
      n.halt_condition_request = 1'b0;
      n.busy = 1'b0;
      n.cnt = 8'h00;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
    end else begin
      if (st_det) n.busy = 1'b1;
      if (sp_det) begin
        n.busy = 1'b0;
        // R8 stop seen on the bus
        n.halt_condition_request = set_w[B_STO];
      end
      case (s.phase)
        P_IDLE: begin
          if (s.cnt != 8'h00) n.cnt = s.cnt - 8'h01;
          if (sp_det) n.cnt = HALF_CYC;
          if (s.mst) begin
            // Own Stop still travelling back through the synchroniser
            if (sp_det) n.mst = 1'b0;
          end else if (s.halt_condition_request) begin
            // R9 R7 silent recovery as if a Stop arrived
            n.halt_condition_request = set_w[B_STO];
            n.addressed = 1'b0;
            n.slv_act = 1'b0;
            n.sda_oe = 1'b0;
          end else if (s.begin_condition_request && !s.busy && s.cnt == 8'h00 && !st_det) begin
            // R5 bus free (and half period after any Stop): go master
            n.phase = P_START;
            n.mst = 1'b1;
            n.rs = 1'b0;
            n.slv_act = 1'b0;
            n.sda_oe = 1'b1;
            n.cnt = HALF_CYC;
          end else if (st_det || sp_det) begin
            if (s.addressed && !s.si) begin
              hw_si = 1'b1;
              code = C_SSTOP;
            end
            n.addressed = 1'b0;
            n.sda_oe = 1'b0;
            n.slv_act = st_det;
            n.first = 1'b1;
            // The Start's own SCL fall wraps this to bit 0
            n.bitcnt = 4'hf;
            n.tx = 1'b0;
          end else if (s.slv_act && scl_r) begin
            // R18 sample into bit 0, oldest bit ends in bit 7
            if (s.bitcnt < 4'd8) n.dat = {s.dat[6:0], sda};
            else n.ackb = sda;
          end else if (s.slv_act && scl_f) begin
            if (s.bitcnt == 4'd8) begin
              n.bitcnt = 4'h0;
              n.first = 1'b0;
              n.sda_oe = 1'b0;
              n.scl_oe = 1'b1;
              n.phase = P_SHOLD;
              if (s.first) begin
                // R19 R23 address phase, slave only
                if (s.aa && adr_hit(s)) begin
                  n.addressed = 1'b1;
                  n.tx = s.dat[0];
                  n.gc = (s.dat[7:1] == 7'h00);
                  hw_si = 1'b1;
                  code = s.dat[0] ? C_SR_OWN : (n.gc ? C_SW_GC : C_SW_OWN);
                end else begin
                  n.slv_act = 1'b0;
                  n.scl_oe = 1'b0;
                  n.phase = P_IDLE;
                end
              end else if (s.addressed) begin
                hw_si = 1'b1;
                if (s.tx) code = s.ackb ? C_STX_NAK : C_STX_ACK;
                else if (s.gc) code = s.ackb ? C_GRX_NAK : C_GRX_ACK;
                else code = s.ackb ? C_SRX_NAK : C_SRX_ACK;
                n.addressed = !s.ackb;
              end else begin
                n.scl_oe = 1'b0;
                n.phase = P_IDLE;
              end
            end else begin
              n.bitcnt = s.bitcnt + 4'h1;
              // R13 R14 ack level chosen by ob
              n.sda_oe = !ob(n);
            end
          end
        end
        P_START: begin
          if (s.cnt != 8'h00) begin
            n.cnt = s.cnt - 8'h01;
          end else begin
            // R6 Start or repeated Start done
            hw_si = 1'b1;
            code = s.rs ? C_RSTART : C_START;
            n.first = 1'b1;
            n.tx = 1'b1;
            n.bitcnt = 4'h0;
            n.scl_oe = 1'b1;
            n.phase = P_HOLD;
          end
        end
        P_LOW: begin
          // SDA moves one clock after SCL is low, never in the same edge
          n.sda_oe = !ob(s);
          if (s.cnt != 8'h00) begin
            n.cnt = s.cnt - 8'h01;
          end else begin
            n.scl_oe = 1'b0;
            n.cnt = HALF_CYC;
            n.phase = P_HIGH;
          end
        end
        P_HIGH: begin
          if (!scl) begin
            n.cnt = HALF_CYC;
          end else if (s.cnt != 8'h00) begin
            n.cnt = s.cnt - 8'h01;
          end else begin
            n.scl_oe = 1'b1;
            n.cnt = HALF_CYC;
            if (s.bitcnt == 4'd8) begin
              hw_si = 1'b1;
              n.ackb = sda;
              n.bitcnt = 4'h0;
              n.first = 1'b0;
              n.phase = P_HOLD;
              if (s.first) begin
                n.tx = !s.dat[0];
                if (s.dat[0]) code = sda ? C_AR_NAK : C_AR_ACK;
                else code = sda ? C_AW_NAK : C_AW_ACK;
              end else if (s.tx) begin
                code = sda ? C_TX_NAK : C_TX_ACK;
              end else begin
                code = sda ? C_RX_NAK : C_RX_ACK;
              end
            end else begin
              // R18 MSB first: bus level shifts in as next bit goes out
              n.dat = {s.dat[6:0], sda};
              n.bitcnt = s.bitcnt + 4'h1;
              n.phase = P_LOW;
            end
          end
        end
        P_HOLD: begin
          // R11 SCL held low while the flag stands; SDA let go once SCL is low
          n.cnt = HALF_CYC;
          n.sda_oe = 1'b0;
          if (!s.si) begin
            if (s.halt_condition_request) begin
              // R8 R7 Stop first; a pending Start follows from idle
              n.sda_oe = 1'b1;
              n.phase = P_STOP1;
            end else if (s.begin_condition_request) begin
              n.sda_oe = 1'b0;
              n.phase = P_RS1;
            end else begin
              n.sda_oe = !ob(s);
              n.phase = P_LOW;
            end
          end
        end
        P_SHOLD: begin
          // R11 slave stretch until software clears the flag
          if (!s.si) begin
            n.scl_oe = 1'b0;
            n.sda_oe = !ob(s);
            n.phase = P_IDLE;
          end
        end
        P_STOP1, P_RS1: begin
          if (s.cnt != 8'h00) begin
            n.cnt = s.cnt - 8'h01;
          end else begin
            n.scl_oe = 1'b0;
            n.cnt = HALF_CYC;
            n.phase = (s.phase == P_STOP1) ? P_STOP2 : P_RS2;
          end
        end
        P_STOP2, P_RS2: begin
          if (!scl) begin
            n.cnt = HALF_CYC;
          end else if (s.cnt != 8'h00) begin
            n.cnt = s.cnt - 8'h01;
          end else begin
            n.cnt = HALF_CYC;
            n.sda_oe = (s.phase == P_RS2);
            n.rs = 1'b1;
            n.phase = (s.phase == P_RS2) ? P_START : P_IDLE;
          end
        end
        default: n.phase = P_IDLE;
      endcase
    end
    // R10 R16 R22 flag and code together; a clear of a standing flag beats a hardware set
    if (hw_si && !s.si) begin
      n.si = 1'b1;
      n.stat = code[7:3];
    end else if (!n.si) begin
      n.stat = STAT_RST;
    end
    n.awrdy = !n.aw_got && !n.bvalid;
    n.wrdy = !n.w_got && !n.bvalid;
    n.arrdy = !n.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // R3 R15 control bits clear, status idle; lines read as released
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s <= '0;
      s.stat <= STAT_RST;
      s.scl_q <= 3'h7;
      s.sda_q <= 3'h7;
    end else begin
      s <= n;
    end
  end

  // Open-drain pins only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = s.scl_oe;
  assign sda_oe_o = s.sda_oe;
  assign s_axi_awready_o = s.awrdy;
  assign s_axi_wready_o = s.wrdy;
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_arready_o = s.arrdy;
  assign s_axi_rvalid_o = s.rvalid;
  assign s_axi_rresp_o = s.rresp;
  assign s_axi_rdata_o = {24'h000000, s.rdata};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  property p_off_quiet;
    !s.en |-> !s.scl_oe && !s.sda_oe && s.phase == P_IDLE;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("active while disabled"); // R1
  property p_off_sto;
    !s.en |=> !s.halt_condition_request;
  endproperty
  a_off_sto: assert property (p_off_sto) else $error("stop kept while disabled"); // R2
  property p_clr_si;
    clr_w[B_SI] && !hw_si |=> !s.si;
  endproperty
  a_clr_si: assert property (p_clr_si) else $error("flag clear ignored"); // R4
  property p_start_free;
    s.phase == P_IDLE ##1 s.phase == P_START |-> $past(!s.busy && s.cnt == 8'h00);
  endproperty
  a_start_free: assert property (p_start_free) else $error("start on busy bus"); // R5
  property p_stop_clr;
    sp_det && !set_w[B_STO] |=> !s.halt_condition_request;
  endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("stop request kept"); // R8
  property p_si_code;
    $rose(s.si) && $past(!set_w[B_SI]) |-> s.stat != STAT_RST;
  endproperty
  a_si_code: assert property (p_si_code) else $error("flag set with idle code"); // R16
  property p_stretch;
    s.si && s.mst && s.phase == P_HOLD |-> s.scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not stretched"); // R11
  property p_stat_hold;
    s.si ##1 s.si |-> $stable(s.stat);
  endproperty
  a_stat_hold: assert property (p_stat_hold) else $error("code moved under flag"); // R22
  property p_dat_hold;
    s.si && !(wr && s.awaddr == A_DAT) |=> $stable(s.dat) || !s.si;
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("data moved under flag"); // R17
  property p_msb_out;
    s.phase == P_LOW && $past(s.phase == P_LOW) && s.mst && s.tx && s.bitcnt < 4'd8
      |-> s.sda_oe == !s.dat[7];
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("wrong data bit driven"); // R18
  property p_mrx_ack;
    s.phase == P_LOW && $past(s.phase == P_LOW) && s.mst && !s.tx && !s.first
      && s.bitcnt == 4'd8 && $stable(s.aa)
      |-> s.sda_oe == s.aa;
  endproperty
  a_mrx_ack: assert property (p_mrx_ack) else $error("wrong ack level"); // R13

  c_master: cover property (s.phase == P_START ##1 s.phase == P_HOLD);
  c_slave: cover property ($rose(s.addressed));
  c_stop: cover property (s.phase == P_STOP2 ##[1:400] sp_det);

endmodule : icr_ctrl

/* File: icr_bus_peer.sv */
// Slave device model for the far side of the two-wire bus.
// Assumes open-drain lines resolved with pull-ups by the bench.
`timescale 1ns/100ps
module icr_bus_peer #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  output logic [7:0] byte_o
);
  int cnt;
  logic first;
  logic [7:0] sh;
  initial begin
    sda_oe_o = 1'b0;
    cnt = 0;
    first = 1'b0;
    sh = 8'h00;
    byte_o = 8'h00;
  end
  // Start or Stop: SDA moving while SCL is high realigns the bit count
  always @(sda_i) begin
    if (scl_i === 1'b1) begin
      cnt = 0;
      first = ~sda_i;
    end
  end
  // Bits arrive most significant first
  always @(posedge scl_i) begin
    sh = {sh[6:0], sda_i};
    cnt = cnt + 1;
  end
  // Acknowledge only our own address, and only the first byte after a Start
  always @(negedge scl_i) begin
    if (cnt == 8) begin
      byte_o = sh;
      sda_oe_o <= first && (sh[7:1] == ADDR);
      first = 1'b0;
    end else begin
      sda_oe_o <= 1'b0;
    end
    if (cnt == 9) cnt = 0;
  end
endmodule : icr_bus_peer

/* File: test_icr_ctrl.sv */
// Self-checking bench for the two-wire controller registers.
// Assumes the package constants and a slave model with address 0x2a.
`timescale 1ns/100ps
module test_icr_ctrl;
  import icr_pkg::*;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [31:0] awaddr = '0, araddr = '0, wdata = '0, rdata, rd_d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic m_scl_oe = 1'b0, m_sda_oe = 1'b0, scl_oe, sda_oe, p_sda_oe, ack;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] p_byte;
  logic bvalid, rvalid, awready, wready, arready;
  wire scl = ~(scl_oe | m_scl_oe);
  wire sda = ~(sda_oe | m_sda_oe | p_sda_oe);
  int error_cnt = 0, comparisons = 0;
  always #12.5 mclk_i = ~mclk_i;
  icr_ctrl icr_ctrl_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda),
    .sda_o(), .sda_oe_o(sda_oe));
  icr_bus_peer icr_bus_peer_i (.scl_i(scl), .sda_i(sda), .sda_oe_o(p_sda_oe), .byte_o(p_byte));
  // ----------------------------------------------------------------
  // Closing and bus tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("Counts: %0d comparisons, %0d errors", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic stuck;
    error_cnt++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict();
  endtask : stuck
  // Handshakes are judged at the falling edge, so the rising edge stays race free
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic aw, w, b;
    int n;
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge mclk_i);
      aw = awvalid & awready; w = wvalid & wready; b = bvalid; resp = bresp;
      @(posedge mclk_i);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) break;
    end
    bready <= 1'b0;
    if (n == 64) stuck();
    @(posedge mclk_i);
  endtask : wr
  task automatic rd(input logic [31:0] a);
    logic ar, rv;
    int n;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge mclk_i);
      ar = arvalid & arready; rv = rvalid; rd_d = rdata; resp = rresp;
      @(posedge mclk_i);
      if (ar) arvalid <= 1'b0;
      if (rv) break;
    end
    rready <= 1'b0;
    if (n == 64) stuck();
    @(posedge mclk_i);
  endtask : rd
  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
    rd(a);
    `CHK(rd_d, e)
    `CHK(resp, r)
  endtask : chk_rd
  task automatic wait_bit(input int b, input logic v);
    int n;
    for (n = 0; n < 3000; n++) begin
      rd(A_SET);
      if (rd_d[b] === v) break;
    end
    if (n == 3000) stuck();
  endtask : wait_bit
  // Two clocks: half of each SCL phase of the 200 ns bench bit
  task automatic half;
    repeat (2) @(posedge mclk_i);
  endtask : half
  // Bench as external master: Start, eight bits and an acknowledge clock
  task automatic ext_addr(input logic [7:0] b, output logic a);
    logic [8:0] s;
    s = {b, 1'b1};
    m_sda_oe <= 1'b1; half(); m_scl_oe <= 1'b1;
    for (int i = 8; i >= 0; i--) begin
      half(); m_sda_oe <= ~s[i];
      half(); m_scl_oe <= 1'b0;
      half(); half(); a = sda; m_scl_oe <= 1'b1;
    end
    repeat (4) half();
    m_scl_oe <= 1'b0;
    half();
  endtask : ext_addr
  task automatic ext_stop;
    m_scl_oe <= 1'b1; half(); m_sda_oe <= 1'b1; half();
    m_scl_oe <= 1'b0; half(); m_sda_oe <= 1'b0; half();
  endtask : ext_stop
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    chk_rd(A_SET, 32'h0, RESP_OK);
    chk_rd(A_STAT, 32'hf8, RESP_OK);
    chk_rd(A_DAT, 32'h0, RESP_OK);
    chk_rd(32'he001c010, 32'h0, RESP_SLVERR);
    wr(32'he001c010, 8'h01);
    `CHK(resp, RESP_SLVERR)
    wr(A_SET, 8'h87);
    `CHK(resp, RESP_OK)
    chk_rd(A_SET, 32'h04, RESP_OK);
    wr(A_CLR, 8'h04);
    chk_rd(A_SET, 32'h0, RESP_OK);
    wr(A_SET, 8'h40);
    wr(A_CLR, 8'h93);
    chk_rd(A_SET, 32'h40, RESP_OK);
    wr(A_CLR, 8'h40);
    chk_rd(A_SET, 32'h0, RESP_OK);
    wr(A_ADR, 8'h79);
    chk_rd(A_ADR, 32'h79, RESP_OK);
    chk_rd(A_CLR, 32'h0, RESP_OK);
    $display("register test done");
  endtask : t_regs
  task automatic t_master(input logic [6:0] a, input logic [7:0] code);
    wr(A_SET, 8'h40);
    wr(A_SET, 8'h20);
    wait_bit(B_SI, 1'b1);
    chk_rd(A_STAT, 32'h08, RESP_OK);
    `CHK(scl, 1'b0)
    wr(A_CLR, 8'h20);
    wr(A_DAT, {a, 1'b0});
    wr(A_CLR, 8'h08);
    wait_bit(B_SI, 1'b1);
    chk_rd(A_STAT, {24'h0, code}, RESP_OK);
    `CHK(p_byte, {a, 1'b0})
    chk_rd(A_DAT, {24'h0, a, 1'b0}, RESP_OK);
    wr(A_SET, 8'h10);
    wr(A_CLR, 8'h08);
    wait_bit(B_STO, 1'b0);
    chk_rd(A_SET, 32'h40, RESP_OK);
    chk_rd(A_STAT, 32'hf8, RESP_OK);
    wr(A_CLR, 8'h40);
    $display("master test done");
  endtask : t_master
  // Master read of one byte; the model leaves SDA released, so it reads all ones
  task automatic t_mread;
    wr(A_SET, 8'h64);
    wait_bit(B_SI, 1'b1);
    wr(A_CLR, 8'h20);
    wr(A_DAT, 8'h55);
    wr(A_CLR, 8'h08);
    wait_bit(B_SI, 1'b1);
    chk_rd(A_STAT, {24'h0, C_AR_ACK}, RESP_OK);
    wr(A_CLR, 8'h08);
    wait_bit(B_SI, 1'b1);
    chk_rd(A_STAT, {24'h0, C_RX_ACK}, RESP_OK);
    chk_rd(A_DAT, 32'hff, RESP_OK);
    wr(A_SET, 8'h10);
    wr(A_CLR, 8'h08);
    wait_bit(B_STO, 1'b0);
    chk_rd(A_SET, 32'h44, RESP_OK);
    wr(A_CLR, 8'h44);
    $display("master read test done");
  endtask : t_mread
  task automatic t_slave;
    wr(A_ADR, 8'h78);
    wr(A_SET, 8'h44);
    ext_addr(8'h78, ack);
    `CHK(ack, 1'b0)
    wait_bit(B_SI, 1'b1);
    chk_rd(A_STAT, 32'h60, RESP_OK);
    `CHK(scl, 1'b0)
    wr(A_SET, 8'h10);
    wr(A_CLR, 8'h08);
    wait_bit(B_STO, 1'b0);
    chk_rd(A_SET, 32'h44, RESP_OK);
    ext_stop();
    // disable, then the own address goes unacknowledged
    wr(A_CLR, 8'h40);
    ext_addr(8'h78, ack);
    `CHK(ack, 1'b1)
    chk_rd(A_SET, 32'h04, RESP_OK);
    ext_stop();
    $display("slave test done");
  endtask : t_slave
  // ----------------------------------------------------------------
  // Run
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    t_regs();
    t_master(7'h2a, C_AW_ACK);
    t_master(7'h31, C_AW_NAK);
    t_mread();
    t_slave();
    give_verdict();
  end
endmodule : test_icr_ctrl
